// ---- hw/xbr_regs.vh ----
`ifndef XBR_REGS_VH
`define XBR_REGS_VH
`define XBR_RST_HOLD 7'd64
`define XBR_RST_OUT 5'd12
`define XBR_PORT_RESET 8'hff
`define XBR_FETCH_START 16'h0000
`define XBR_PH_ALE 3'd1
`define XBR_PH_ADDR 3'd2
`define XBR_PH_STROBE 3'd3
`define XBR_PH_HOLD 3'd4
`define XBR_PH_DONE 3'd5
`define XBR_PH_IDLE 3'd0
`endif

// ---- hw/xbr_reset_ctrl.v ----
`timescale 1ns/10ps
`include "xbr_regs.vh"
module xbr_reset_ctrl (
	// Clock and pin reset.
	input wire clk_i,
	input wire reset_i,
	// Internal reset request and fetch select pin.
	input wire int_reset_req_i,
	input wire external_fetch_select_i,
	// Reset outcome.
	output reg core_reset_o,
	output wire pin_force_o,
	output reg rst_drive_o,
	output reg fetch_external_o
);
	reg [6:0] hold_cnt;
	reg [4:0] out_cnt;
	// The pad forces the ports at once, with no clock needed.
	assign pin_force_o = reset_i;
	always @(posedge clk_i) begin
		if (reset_i) begin
			if (hold_cnt != `XBR_RST_HOLD)
				hold_cnt <= hold_cnt + 7'd1;
			else
				core_reset_o <= 1'b1;
			// Strap caught while reset is held.
			fetch_external_o <= ~external_fetch_select_i;
			out_cnt <= 5'd0;
			rst_drive_o <= 1'b0;
		end else begin
			hold_cnt <= 7'd0;
			if (int_reset_req_i && !rst_drive_o) begin
				rst_drive_o <= 1'b1;
				out_cnt <= `XBR_RST_OUT;
				core_reset_o <= 1'b1;
			end else if (rst_drive_o) begin
				if (out_cnt == 5'd1) begin
					rst_drive_o <= 1'b0;
					core_reset_o <= 1'b0;
				end
				out_cnt <= out_cnt - 5'd1;
			end else begin
				core_reset_o <= 1'b0;
			end
		end
	end
	initial begin
		hold_cnt = 7'd0;
		out_cnt = 5'd0;
		core_reset_o = 1'b1;
		rst_drive_o = 1'b0;
		fetch_external_o = 1'b0;
	end
endmodule

// ---- hw/xbr_slave_port.v ----
`timescale 1ns/10ps
`include "xbr_regs.vh"
module xbr_slave_port (
	// Clock and reset.
	input wire clk_i,
	input wire reset_i,
	// Mode.
	input wire wide_mode_i,
	// Host strobes and bus, active low strobes.
	input wire rd_n_i,
	input wire wr_n_i,
	input wire [7:0] ad_i,
	input wire [7:0] a_i,
	// Core side.
	input wire [15:0] tx_data_i,
	output reg [15:0] rx_data_o,
	output reg rx_valid_o,
	output reg rd_done_o,
	output wire drive_lo_o,
	output wire drive_hi_o,
	output wire [15:0] drive_data_o
);
	reg wr_n_d;
	reg rd_n_d;
	// Host strobes steer each slave cycle.
	assign drive_lo_o = ~rd_n_i;
	assign drive_hi_o = ~rd_n_i & wide_mode_i;
	assign drive_data_o = tx_data_i;
	always @(posedge clk_i) begin
		if (reset_i) begin
			wr_n_d <= 1'b1;
			rd_n_d <= 1'b1;
			rx_data_o <= 16'h0000;
			rx_valid_o <= 1'b0;
			rd_done_o <= 1'b0;
		end else begin
			wr_n_d <= wr_n_i;
			rd_n_d <= rd_n_i;
			rx_valid_o <= 1'b0;
			rd_done_o <= ~rd_n_d & rd_n_i;
			// Data is taken on the strobe's rising edge.
			if (!wr_n_d && wr_n_i) begin
				rx_valid_o <= 1'b1;
				rx_data_o[7:0] <= ad_i;
				rx_data_o[15:8] <= wide_mode_i ? a_i : 8'h00;
			end
		end
	end
endmodule

// ---- hw/xbr_ext_bus.v ----
`timescale 1ns/10ps
`include "xbr_regs.vh"
module xbr_ext_bus (
	// Clock and reset pin level (high means asserted).
	input wire clk_i,
	input wire reset_i,
	// Core requests for external data moves.
	input wire req_i,
	input wire req_write_i,
	input wire [15:0] req_addr_i,
	input wire [7:0] req_wdata_i,
	output wire req_ready_o,
	output reg [7:0] rdata_o,
	output reg done_o,
	// Power modes and internal reset sources.
	input wire idle_i,
	input wire power_down_i,
	input wire int_reset_req_i,
	output wire wake_o,
	output wire core_reset_o,
	output wire rst_drive_o,
	// Fetch select strap and result.
	input wire external_fetch_select_i,
	output wire fetch_external_o,
	output wire [15:0] fetch_start_o,
	// Slave port mode and core side.
	input wire slave_mode_i,
	input wire wide_mode_i,
	input wire [15:0] slave_tx_i,
	output wire [15:0] slave_rx_o,
	output wire slave_rx_valid_o,
	output wire slave_rd_done_o,
	// Low shared bus pins.
	input wire [7:0] ad_i,
	output reg [7:0] ad_o,
	output wire [7:0] ad_oe_o,
	// High address pins.
	input wire [7:0] a_i,
	output reg [7:0] a_o,
	output wire [7:0] a_oe_o,
	// Strobe pins.
	input wire rd_n_i,
	output reg rd_n_o,
	output wire rd_n_oe_o,
	input wire wr_n_i,
	output reg wr_n_o,
	output wire wr_n_oe_o,
	output reg ale_o
);
	reg [2:0] phase;
	reg [2:0] next_phase;
	reg is_write;
	reg ad_drive;
	reg [15:0] addr;
	reg [7:0] wdata;
	wire pin_force;
	wire sp_lo;
	wire sp_hi;
	wire [15:0] sp_data;
	wire master_ok;

	xbr_reset_ctrl u_reset (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.int_reset_req_i(int_reset_req_i),
		.external_fetch_select_i(external_fetch_select_i),
		.core_reset_o(core_reset_o),
		.pin_force_o(pin_force),
		.rst_drive_o(rst_drive_o),
		.fetch_external_o(fetch_external_o)
	);

	xbr_slave_port u_slave (
		.clk_i(clk_i),
		.reset_i(core_reset_o),
		.wide_mode_i(wide_mode_i),
		.rd_n_i(rd_n_i),
		.wr_n_i(wr_n_i),
		.ad_i(ad_i),
		.a_i(a_i),
		.tx_data_i(slave_tx_i),
		.rx_data_o(slave_rx_o),
		.rx_valid_o(slave_rx_valid_o),
		.rd_done_o(slave_rd_done_o),
		.drive_lo_o(sp_lo),
		.drive_hi_o(sp_hi),
		.drive_data_o(sp_data)
	);

	assign fetch_start_o = `XBR_FETCH_START;
	// Only a pin reset assertion wakes the core from either low-power mode; an internal reset request does not.
	assign wake_o = reset_i & (idle_i | power_down_i);
	assign master_ok = ~slave_mode_i & ~core_reset_o;
	assign req_ready_o = master_ok && phase == `XBR_PH_IDLE;

	// Port pins sit released (reset state, all ones) while forced.
	assign ad_oe_o = (pin_force || core_reset_o) ? 8'h00 :
		slave_mode_i ? {8{sp_lo}} : {8{ad_drive}};
	assign a_oe_o = (pin_force || core_reset_o) ? 8'h00 :
		slave_mode_i ? {8{sp_hi}} :
		{8{phase != `XBR_PH_IDLE}};
	assign rd_n_oe_o = master_ok & ~pin_force;
	assign wr_n_oe_o = master_ok & ~pin_force;

	always @* begin
		next_phase = phase;
		case (phase)
			`XBR_PH_IDLE: begin
				if (req_i && master_ok)
					next_phase = `XBR_PH_ALE;
			end
			`XBR_PH_ALE: next_phase = `XBR_PH_ADDR;
			`XBR_PH_ADDR: next_phase = `XBR_PH_STROBE;
			`XBR_PH_STROBE: next_phase = `XBR_PH_HOLD;
			`XBR_PH_HOLD: next_phase = `XBR_PH_DONE;
			`XBR_PH_DONE: next_phase = `XBR_PH_IDLE;
			default: next_phase = `XBR_PH_IDLE;
		endcase
	end

	always @(posedge clk_i) begin
		if (core_reset_o || slave_mode_i) begin
			phase <= `XBR_PH_IDLE;
			is_write <= 1'b0;
			ad_drive <= 1'b0;
			addr <= 16'h0000;
			wdata <= 8'h00;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			ale_o <= 1'b0;
			done_o <= 1'b0;
			if (core_reset_o) begin
				rdata_o <= 8'h00;
				ad_o <= `XBR_PORT_RESET;
				a_o <= `XBR_PORT_RESET;
			end else begin
				// Registered, so a new word reaches the pins a cycle late.
				ad_o <= sp_data[7:0];
				a_o <= sp_data[15:8];
			end
		end else begin
			phase <= next_phase;
			done_o <= 1'b0;
			case (phase)
				`XBR_PH_IDLE: begin
					// The strobe stays low unless a data move starts.
					if (req_i) begin
						addr <= req_addr_i;
						is_write <= req_write_i;
						wdata <= req_wdata_i;
						ale_o <= 1'b1;
						ad_o <= req_addr_i[7:0];
						a_o <= req_addr_i[15:8];
						ad_drive <= 1'b1;
					end
				end
				`XBR_PH_ALE: begin
					// Address stays put across the falling edge.
					ale_o <= 1'b0;
				end
				`XBR_PH_ADDR: begin
					// Data phase only after the latch has closed.
					if (is_write) begin
						ad_o <= wdata;
						wr_n_o <= 1'b0;
					end else begin
						ad_drive <= 1'b0;
						rd_n_o <= 1'b0;
					end
				end
				`XBR_PH_STROBE: begin
					if (!is_write)
						rdata_o <= ad_i;
				end
				`XBR_PH_HOLD: begin
					rd_n_o <= 1'b1;
					wr_n_o <= 1'b1;
				end
				`XBR_PH_DONE: begin
					ad_drive <= 1'b0;
					done_o <= 1'b1;
				end
				default: ale_o <= 1'b0;
			endcase
		end
	end
endmodule

// ---- verification/xbr_mem_model.sv ----
`timescale 1ns/10ps
module xbr_mem_model (
	// Pins seen from the memory side.
	input wire ale_i,
	input wire [7:0] ad_i,
	input wire [7:0] a_i,
	input wire rd_n_i,
	input wire wr_n_i,
	// Read data for the low bus.
	output logic [7:0] q_o,
	output logic q_oe_o
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	// Only the falling edge counts, so a late address is caught.
	always @(negedge ale_i) begin
		addr = {a_i, ad_i};
	end
	// Data is taken as the strobe rises, while it is still valid.
	always @(posedge wr_n_i) begin
		mem[addr] = ad_i;
	end
	always @* begin
		q_oe_o = !rd_n_i;
		q_o = mem[addr];
	end
endmodule

// ---- verification/xbr_ext_bus_props.sv ----
`timescale 1ns/10ps
module xbr_ext_bus_props (
	// Clock, reset and core side.
	input wire clk_i,
	input wire reset_i,
	input wire req_i,
	input wire req_write_i,
	input wire [15:0] req_addr_i,
	input wire [7:0] req_wdata_i,
	input wire req_ready_o,
	input wire done_o,
	input wire rst_drive_o,
	input wire fetch_external_o,
	// Pins.
	input wire slave_mode_i,
	input wire wide_mode_i,
	input wire rd_n_i,
	input wire [7:0] ad_o,
	input wire [7:0] ad_oe_o,
	input wire [7:0] a_o,
	input wire [7:0] a_oe_o,
	input wire rd_n_o,
	input wire wr_n_o,
	input wire ale_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_take;
		req_i && req_ready_o;
	endsequence
	a_ale_cause: assert property ($rose(ale_o) |->
		$past(req_i && req_ready_o)) else $error("stray latch strobe");
	a_addr_phase: assert property (s_take |=> ale_o &&
		ad_oe_o == 8'hff && ad_o == $past(req_addr_i[7:0]) &&
		a_o == $past(req_addr_i[15:8]) ##1 !ale_o)
		else $error("address phase wrong");
	a_write_phase: assert property (s_take ##0 req_write_i |->
		##3 !wr_n_o && ad_o == $past(req_wdata_i, 3))
		else $error("write phase wrong");
	a_read_strobe: assert property (s_take ##0 !req_write_i |->
		##3 !rd_n_o && ad_oe_o == 8'h00 ##2 rd_n_o)
		else $error("read strobe wrong");
	a_done_time: assert property (s_take |=> !done_o [*5]
		##1 done_o) else $error("done late or early");
	a_pins_free: assert property (disable iff (1'b0) reset_i |->
		ad_oe_o == 8'h00 && a_oe_o == 8'h00) else $error("pins held");
	a_rst_out_len: assert property ($rose(rst_drive_o) |->
		rst_drive_o [*8] ##1 rst_drive_o [*4] ##1 !rst_drive_o)
		else $error("reset drive length wrong");
	a_strap_held: assert property ($past(!reset_i) |->
		$stable(fetch_external_o)) else $error("strap moved");
	a_slave_drive: assert property (slave_mode_i && !rd_n_i |->
		ad_oe_o == 8'hff && a_oe_o == {8{wide_mode_i}})
		else $error("slave drive wrong");
endmodule
bind xbr_ext_bus xbr_ext_bus_props u_props (.*);

// ---- verification/xbr_ext_bus_test.sv ----
`timescale 1ns/10ps
module xbr_ext_bus_test;
	logic clk_i, reset_i, req_i, req_write_i, idle_i, power_down_i;
	logic int_reset_req_i, external_fetch_select_i, slave_mode_i;
	logic wide_mode_i, h_rd_n, h_wr_n, q_oe;
	logic [15:0] req_addr_i, slave_tx_i;
	logic [7:0] req_wdata_i, h_ad, h_a, q;
	wire req_ready_o, done_o, wake_o, core_reset_o, rst_drive_o;
	wire fetch_external_o, slave_rx_valid_o, slave_rd_done_o, rd_n_o;
	wire rd_n_oe_o, wr_n_o, wr_n_oe_o, ale_o;
	wire [7:0] rdata_o, ad_o, ad_oe_o, a_o, a_oe_o;
	wire [15:0] fetch_start_o, slave_rx_o;
	int n_errors, tests_run, i, c;
	// Each pin carries whichever party enables its driver.
	wire rd_n_i = rd_n_oe_o ? rd_n_o : h_rd_n;
	wire wr_n_i = wr_n_oe_o ? wr_n_o : h_wr_n;
	wire [7:0] a_i = a_oe_o[0] ? a_o : h_a;
	wire [7:0] ad_i = ad_oe_o[0] ? ad_o : (q_oe && !slave_mode_i) ? q : h_ad;
	xbr_ext_bus uut (.*);
	xbr_mem_model mem (.ale_i(ale_o), .ad_i(ad_i), .a_i(a_i),
		.rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .q_o(q), .q_oe_o(q_oe));
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	task chk(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task xfer(input logic wr, input logic [15:0] adr, input logic [7:0] d);
		req_i = 1;
		req_write_i = wr;
		req_addr_i = adr;
		req_wdata_i = d;
		for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) tick(1);
		tick(1);
		req_i = 0;
		for (c = 0; c < 9 && done_o !== 1'b1; c++) tick(1);
		if (i == 20 || c == 9) begin
			n_errors++;
			test_done;
		end
	endtask
	task t_reset;
		idle_i = 1;
		reset_i = 1;
		tick(1);
		chk("wake", wake_o, 1);
		chk("oe", {ad_oe_o, rd_n_oe_o, wr_n_oe_o}, 16'h0000);
		tick(70);
		chk("core_rst", core_reset_o, 1);
		reset_i = 0;
		idle_i = 0;
		external_fetch_select_i = 1;
		tick(2);
		chk("fetch_ext", fetch_external_o, 1);
		chk("start", fetch_start_o, 16'h0000);
		reset_i = 1;
		power_down_i = 1;
		tick(20);
		chk("wake_pd", wake_o, 1);
		chk("short_rst", core_reset_o, 0);
		reset_i = 0;
		power_down_i = 0;
		tick(2);
		chk("fetch_int", fetch_external_o, 0);
		$display("reset test done");
	endtask
	task t_xfer;
		xfer(1, 16'h12a5, 8'h3c);
		xfer(1, 16'h12a6, 8'hc3);
		xfer(0, 16'h12a5, 8'h00);
		chk("rd0", rdata_o, 8'h3c);
		xfer(0, 16'h12a6, 8'h00);
		chk("rd1", rdata_o, 8'hc3);
		$display("transfer test done");
	endtask
	task t_irst;
		int_reset_req_i = 1;
		tick(1);
		int_reset_req_i = 0;
		c = 0;
		for (i = 0; i < 30; i++) begin
			c = c + (rst_drive_o === 1'b1);
			tick(1);
		end
		chk("rst_out", c, 12);
		$display("internal reset test done");
	endtask
	task t_slave;
		slave_mode_i = 1;
		wide_mode_i = 1;
		slave_tx_i = 16'hc33c;
		h_ad = 8'h5a;
		h_a = 8'ha5;
		h_wr_n = 0;
		tick(1);
		h_wr_n = 1;
		for (i = 0; i < 5 && slave_rx_valid_o !== 1'b1; i++) tick(1);
		chk("rxv", slave_rx_valid_o, 1);
		chk("rx", slave_rx_o, 16'ha55a);
		chk("st_oe", {rd_n_oe_o, wr_n_oe_o}, 16'h0000);
		h_rd_n = 0;
		tick(1);
		chk("hi_dat", a_i, 8'hc3);
		chk("lo_dat", ad_i, 8'h3c);
		h_rd_n = 1;
		tick(1);
		chk("rd_done", slave_rd_done_o, 1);
		wide_mode_i = 0;
		h_rd_n = 0;
		tick(1);
		chk("lo_oe", ad_oe_o, 8'hff);
		chk("hi_oe", a_oe_o, 8'h00);
		h_rd_n = 1;
		tick(1);
		chk("rel", ad_oe_o, 8'h00);
		slave_mode_i = 0;
		$display("slave test done");
	endtask
	initial begin
		{n_errors, tests_run} = 0;
		{reset_i, h_rd_n, h_wr_n} = 3'b111;
		{req_i, req_write_i, idle_i, power_down_i} = 4'h0;
		{int_reset_req_i, slave_mode_i, wide_mode_i} = 3'b000;
		external_fetch_select_i = 0;
		{h_ad, h_a, req_wdata_i} = 24'hff_ff00;
		{req_addr_i, slave_tx_i} = 32'h0000_0000;
		tick(16);
		reset_i = 0;
		tick(2);
		chk("rst_rel", core_reset_o, 0);
		t_reset;
		t_xfer;
		t_irst;
		t_slave;
		test_done;
	end
endmodule
